/* dv/cfs_skip_unit_assertions.sv */
module cfs_skip_unit_assertions
	import cfs_pkg::*;
(
	input wire logic sys_clk, // clock
	input wire logic rst_n, // sync reset
	input cfs_fetch_s fetch, // fetched word
	input cfs_operand_s operand, // acc and m(dp)
	input wire logic [1:0] ext_req_set, // flag set pulses
	input wire logic skip_next_q, // skip pending
	input wire logic operand_next_q, // immediate pending
	input wire logic inhibit_q, // swallow pulse
	input wire logic [1:0] ext_request_flag_q, // request flags
	input wire logic [1:0] ext_irq_enable_q // enables
);
	timeunit 1ns;
	timeprecision 1ps;
	logic run;
	logic imm;
	logic eq;
	// run: word decoded as opcode; imm: word used as operand
	assign run = fetch.valid && !skip_next_q && !operand_next_q;
	assign imm = fetch.valid && operand_next_q;
	assign eq = operand.acc == operand.mem;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	a_imm_operand: assert property (
		run && fetch.word == 10'h025 |=> operand_next_q && !skip_next_q)
		else $error("immediate compare took no operand");
	a_imm_hit: assert property (
		imm && operand.acc == fetch.word[3:0]
		|=> skip_next_q && !operand_next_q)
		else $error("equal immediate did not skip");
	a_imm_miss: assert property (
		imm && operand.acc != fetch.word[3:0]
		|=> !skip_next_q && !operand_next_q)
		else $error("unequal immediate skipped");
	a_mem_compare: assert property (
		run && fetch.word == 10'h026
		|=> skip_next_q == $past(eq) && !operand_next_q)
		else $error("memory compare gave wrong skip");
	a_ext0_skip: assert property (
		run && fetch.word == 10'h038 && !ext_irq_enable_q[0]
		&& ext_request_flag_q[0] && !ext_req_set[0]
		|=> skip_next_q && !ext_request_flag_q[0])
		else $error("ext0 test did not skip and clear");
	a_ext0_set_wins: assert property (
		run && fetch.word == 10'h038 && !ext_irq_enable_q[0]
		&& ext_request_flag_q[0] && ext_req_set[0]
		|=> skip_next_q && ext_request_flag_q[0])
		else $error("ext0 request lost to the test clear");
	a_ext0_hold: assert property (
		run && fetch.word == 10'h038 && !ext_req_set[0]
		&& (ext_irq_enable_q[0] || !ext_request_flag_q[0])
		|=> !skip_next_q
		&& ext_request_flag_q[0] == $past(ext_request_flag_q[0]))
		else $error("ext0 test acted when it should not");
	a_ext1_skip: assert property (
		run && fetch.word == 10'h039 && !ext_irq_enable_q[1]
		&& ext_request_flag_q[1] && !ext_req_set[1]
		|=> skip_next_q && !ext_request_flag_q[1])
		else $error("ext1 test did not skip and clear");
	a_ext1_hold: assert property (
		run && fetch.word == 10'h039 && !ext_req_set[1]
		&& (ext_irq_enable_q[1] || !ext_request_flag_q[1])
		|=> !skip_next_q
		&& ext_request_flag_q[1] == $past(ext_request_flag_q[1]))
		else $error("ext1 test acted when it should not");
	a_swallow_one: assert property (
		fetch.valid && skip_next_q
		|=> inhibit_q && !skip_next_q && !operand_next_q)
		else $error("skipped word was decoded");
	a_skip_waits: assert property (
		skip_next_q && !fetch.valid |=> $stable(skip_next_q) && !inhibit_q)
		else $error("skip lost during a fetch gap");
endmodule

bind cfs_skip_unit cfs_skip_unit_assertions u_chk (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.fetch(fetch),
	.operand(operand),
	.ext_req_set(ext_req_set),
	.skip_next_q(skip_next_q),
	.operand_next_q(operand_next_q),
	.inhibit_q(inhibit_q),
	.ext_request_flag_q(ext_request_flag_q),
	.ext_irq_enable_q(ext_irq_enable_q)
);

/* dv/tb_compare_and_flag_skip_instructions.sv */
module tb_compare_and_flag_skip_instructions
	import cfs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [1:0] ctrl, set;
		logic [9:0] w1;
		logic [3:0] imm, acc, mem;
		logic skip;
		logic [1:0] flags;
	} cfs_row_s;
	// ctrl, flag set, word, immediate, acc, mem, skip, flags after
	cfs_row_s rows [11] = '{
		'{2'h0, 2'h0, 10'h025, 4'h5, 4'h5, 4'h0, 1'h1, 2'h0},
		'{2'h0, 2'h0, 10'h025, 4'hf, 4'he, 4'h0, 1'h0, 2'h0},
		'{2'h0, 2'h0, 10'h025, 4'h0, 4'h0, 4'h0, 1'h1, 2'h0},
		'{2'h0, 2'h0, 10'h026, 4'h0, 4'h9, 4'h9, 1'h1, 2'h0},
		'{2'h0, 2'h0, 10'h026, 4'h0, 4'h0, 4'hf, 1'h0, 2'h0},
		'{2'h0, 2'h1, 10'h038, 4'h0, 4'h0, 4'h0, 1'h1, 2'h0},
		'{2'h0, 2'h0, 10'h038, 4'h0, 4'h0, 4'h0, 1'h0, 2'h0},
		'{2'h1, 2'h1, 10'h038, 4'h0, 4'h0, 4'h0, 1'h0, 2'h1},
		'{2'h2, 2'h2, 10'h039, 4'h0, 4'h0, 4'h0, 1'h0, 2'h3},
		'{2'h0, 2'h0, 10'h039, 4'h0, 4'h0, 4'h0, 1'h1, 2'h1},
		'{2'h0, 2'h0, 10'h038, 4'h0, 4'h0, 4'h0, 1'h1, 2'h0}
	};
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	cfs_fetch_s fetch = '0;
	cfs_operand_s operand = '0;
	logic [1:0] ext_req_set = 2'h0;
	logic skip_next_q, operand_next_q, inhibit_q, irq_q;
	logic [1:0] ext_request_flag_q, ext_irq_enable_q, s_bresp, s_rresp, resp;
	logic [4:0] s_awaddr = 5'h00;
	logic [4:0] s_araddr = 5'h00;
	logic [31:0] s_wdata = 32'h0;
	logic [31:0] s_rdata, rdat;
	logic [3:0] s_wstrb = 4'hf;
	logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
	logic s_arvalid = 1'b0, s_rready = 1'b0;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	int n_fail = 0;
	int total_checks = 0;

	cfs_skip_unit u_cfs_skip_unit (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.fetch(fetch),
		.operand(operand),
		.ext_req_set(ext_req_set),
		.skip_next_q(skip_next_q),
		.operand_next_q(operand_next_q),
		.inhibit_q(inhibit_q),
		.ext_request_flag_q(ext_request_flag_q),
		.ext_irq_enable_q(ext_irq_enable_q),
		.irq_q(irq_q),
		.s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid),
		.s_awready(s_awready),
		.s_wdata(s_wdata),
		.s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid),
		.s_wready(s_wready),
		.s_bresp(s_bresp),
		.s_bvalid(s_bvalid),
		.s_bready(s_bready),
		.s_araddr(s_araddr),
		.s_arvalid(s_arvalid),
		.s_arready(s_arready),
		.s_rdata(s_rdata),
		.s_rresp(s_rresp),
		.s_rvalid(s_rvalid),
		.s_rready(s_rready)
	);

	always #25 sys_clk = ~sys_clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop;
		if (n_fail == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// each channel let go at its own handshake edge
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
		end while (!s_bvalid);
		resp = s_bresp;
		s_bready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [4:0] a);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_arready) s_arvalid <= 1'b0;
		end while (!s_rvalid);
		rdat = s_rdata;
		resp = s_rresp;
		s_rready <= 1'b0;
		@(posedge sys_clk);
	endtask

	// no clear here, so back to back words never assign twice
	task automatic feed(input logic [9:0] w);
		fetch <= '{1'b1, w};
		@(posedge sys_clk);
	endtask

	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk({skip_next_q, operand_next_q, inhibit_q, irq_q}, 0);
		rd(5'h00);
		chk(rdat, 0);
		foreach (rows[i]) begin
			wr(5'h00, {30'h0, rows[i].ctrl});
			chk(resp, 2'h0);
			chk(ext_irq_enable_q, rows[i].ctrl);
			ext_req_set <= rows[i].set;
			operand <= '{rows[i].acc, rows[i].mem};
			@(posedge sys_clk);
			ext_req_set <= 2'h0;
			feed(rows[i].w1);
			if (rows[i].w1 == 10'h025) feed({6'h0, rows[i].imm});
			fetch <= '0;
			#1;
			chk(skip_next_q, rows[i].skip);
			chk(ext_request_flag_q, rows[i].flags);
			@(posedge sys_clk);
			feed(10'h000);
			fetch <= '0;
			#1;
			chk(inhibit_q, rows[i].skip);
		end
		// a swallowed two-word opcode must not take an operand
		@(posedge sys_clk);
		operand <= '{4'h3, 4'h3};
		feed(10'h026);
		feed(10'h025);
		fetch <= '0;
		#1;
		chk({operand_next_q, inhibit_q}, 1);
		rd(5'h04);
		chk(rdat, 0);
		rd(5'h08);
		chk(rdat, 32'hf);
		chk(irq_q, 0);
		wr(5'h0c, 32'h1);
		#1;
		chk(irq_q, 1);
		wr(5'h08, 32'h1);
		#1;
		chk(irq_q, 0);
		rd(5'h08);
		chk(rdat, 32'he);
		rd(5'h14);
		chk(resp, 2'h2);
		chk(rdat, 32'h0);
		wr(5'h18, 32'h3);
		chk(resp, 2'h2);
		// a request landing with its own test: the set wins
		ext_req_set <= 2'h1;
		@(posedge sys_clk);
		feed(10'h038);
		ext_req_set <= 2'h0;
		fetch <= '0;
		#1;
		chk(skip_next_q, 1);
		chk(ext_request_flag_q, 2'h1);
		// reset in mid-run drops the pending skip and the flags
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		feed(10'h025);
		fetch <= '0;
		#1;
		chk({skip_next_q, inhibit_q, irq_q, ext_request_flag_q}, 0);
		chk(operand_next_q, 1);
		report_and_stop;
	end

	// cuts a hang short; the run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge sys_clk);
		n_fail++;
		report_and_stop;
	end
endmodule

/* hw/cfs_axil_slave.sv */
`include "cfs_map.svh"

module cfs_axil_slave
	import cfs_pkg::*;
(
	input wire logic sys_clk, // instruction cycle clock
	input wire logic rst_n, // sync reset
	input wire logic [4:0] s_awaddr, // write address
	input wire logic s_awvalid, // write address valid
	output logic s_awready, // write address ready
	input wire logic [31:0] s_wdata, // write data
	input wire logic [3:0] s_wstrb, // byte strobes
	input wire logic s_wvalid, // write data valid
	output logic s_wready, // write data ready
	output logic [1:0] s_bresp, // write response
	output logic s_bvalid, // write response valid
	input wire logic s_bready, // write response ready
	input wire logic [4:0] s_araddr, // read address
	input wire logic s_arvalid, // read address valid
	output logic s_arready, // read address ready
	output logic [31:0] s_rdata, // read data
	output logic [1:0] s_rresp, // read response
	output logic s_rvalid, // read data valid
	input wire logic s_rready, // read data ready
	output cfs_regwr_s reg_wr, // one-cycle write strobe
	output logic [4:0] rd_addr, // read lookup address
	input wire logic [31:0] rd_data, // read lookup result
	input wire logic rd_hit // read address is mapped
);

	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic [4:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_fire;

	// both halves held and no answer pending
	assign wr_fire = !awready_q && !wready_q && !bvalid_q;
	assign reg_wr = '{en: wr_fire, addr: awaddr_q, data: wdata_q,
		strb: wstrb_q};
	assign rd_addr = s_araddr;

	function automatic logic mapped(input logic [4:0] a);
		mapped = a == `CFS_OFS_CTRL || a == `CFS_OFS_FLAGS ||
			a == `CFS_OFS_EVT_STAT || a == `CFS_OFS_EVT_MASK ||
			a == `CFS_OFS_STATE;
	endfunction

	// write channels: address and data taken in either order
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= `CFS_RESP_OKAY;
			awaddr_q <= 5'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (awready_q && s_awvalid) begin
				awready_q <= 1'b0;
				awaddr_q <= s_awaddr;
			end
			if (wready_q && s_wvalid) begin
				wready_q <= 1'b0;
				wdata_q <= s_wdata;
				wstrb_q <= s_wstrb;
			end
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= mapped(awaddr_q) ? `CFS_RESP_OKAY
					: `CFS_RESP_SLVERR;
			end
			if (bvalid_q && s_bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// read channel: data captured on the address handshake
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `CFS_RESP_OKAY;
		end else if (arready_q && s_arvalid) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_data;
			rresp_q <= rd_hit ? `CFS_RESP_OKAY : `CFS_RESP_SLVERR;
		end else if (rvalid_q && s_rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	assign s_awready = awready_q;
	assign s_wready = wready_q;
	assign s_bvalid = bvalid_q;
	assign s_bresp = bresp_q;
	assign s_arready = arready_q;
	assign s_rvalid = rvalid_q;
	assign s_rdata = rdata_q;
	assign s_rresp = rresp_q;

endmodule

/* hw/cfs_skip_unit.sv */
// Behaviour
// - the immediate compare skips the next instruction when acc equals n.
// - the immediate compare is two words, 0000100101 then n in bits 3:0.
// - the memory compare skips the next instruction when acc equals mem.
// - the memory compare is the single one-cycle word 0000100110.
// - with ext0 enable low, a set ext0 flag skips and is then cleared.
// - word 0000111000 tests ext0; with enable bit 0 high it is a no-op.
// - with ext1 enable low, a set ext1 flag skips and is then cleared.
// - word 0000111001 tests ext1; with enable bit 1 high it is a no-op.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`include "cfs_map.svh"

module cfs_skip_unit
	import cfs_pkg::*;
(
	input wire logic sys_clk, // instruction cycle clock
	input wire logic rst_n, // sync reset, active low
	input cfs_fetch_s fetch, // fetched word and its valid
	input cfs_operand_s operand, // accumulator and m(dp)
	input wire logic [1:0] ext_req_set, // request flag set pulses
	output logic skip_next_q, // next fetched word is inhibited
	output logic operand_next_q, // next word is an immediate
	output logic inhibit_q, // pulse: a word was swallowed
	output logic [1:0] ext_request_flag_q, // ext1/ext0 flags
	output logic [1:0] ext_irq_enable_q, // ext1/ext0 enables
	output logic irq_q, // level interrupt
	input wire logic [4:0] s_awaddr, // write address
	input wire logic s_awvalid, // write address valid
	output logic s_awready, // write address ready
	input wire logic [31:0] s_wdata, // write data
	input wire logic [3:0] s_wstrb, // byte strobes
	input wire logic s_wvalid, // write data valid
	output logic s_wready, // write data ready
	output logic [1:0] s_bresp, // write response
	output logic s_bvalid, // write response valid
	input wire logic s_bready, // write response ready
	input wire logic [4:0] s_araddr, // read address
	input wire logic s_arvalid, // read address valid
	output logic s_arready, // read address ready
	output logic [31:0] s_rdata, // read data
	output logic [1:0] s_rresp, // read response
	output logic s_rvalid, // read data valid
	input wire logic s_rready // read data ready
);

	cfs_state_e state_q, state_d;
	cfs_regwr_s reg_wr;
	logic [4:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_hit;
	logic [`CFS_EVT_W-1:0] evt_stat_q, evt_mask_q, evt_set;
	logic [1:0] flag_clr;
	logic [1:0] snz_hit;
	logic [1:0] snz_nop;
	logic is_imm, is_mem, cmp_mem_eq, cmp_imm_eq;
	logic word_live;

	cfs_axil_slave u_bus (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid),
		.s_awready(s_awready),
		.s_wdata(s_wdata),
		.s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid),
		.s_wready(s_wready),
		.s_bresp(s_bresp),
		.s_bvalid(s_bvalid),
		.s_bready(s_bready),
		.s_araddr(s_araddr),
		.s_arvalid(s_arvalid),
		.s_arready(s_arready),
		.s_rdata(s_rdata),
		.s_rresp(s_rresp),
		.s_rvalid(s_rvalid),
		.s_rready(s_rready),
		.reg_wr(reg_wr),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_hit(rd_hit)
	);

	// a word is decoded only in the run state
	assign word_live = fetch.valid && state_q == CFS_ST_RUN;

	// opcode decode of the two compares
	assign is_imm = word_live
		&& fetch.word == `CFS_OP_SKIP_ACC_IMM;
	assign is_mem = word_live
		&& fetch.word == `CFS_OP_SKIP_ACC_MEM;
	assign cmp_mem_eq = operand.acc == operand.mem;
	// only the low nibble of the operand word matters
	assign cmp_imm_eq = operand.acc == fetch.word[3:0];

	// flag tests, one lane per external request
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_snz
			logic op_hit;
			// opcodes 038 and 039 differ only in bit 0
			assign op_hit = word_live && fetch.word ==
				(`CFS_OP_SKIP_EXT0 | 10'(g));
			// enable high turns the test into a no-op
			assign snz_nop[g] = op_hit && ext_irq_enable_q[g];
			assign snz_hit[g] = op_hit && !ext_irq_enable_q[g]
				&& ext_request_flag_q[g];
			assign flag_clr[g] = snz_hit[g];
		end
	endgenerate

	// sequencer: run, wait for immediate, swallow one word
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			CFS_ST_RUN: begin
				if (is_imm)
					state_d = CFS_ST_OPERAND;
				else if (is_mem && cmp_mem_eq)
					state_d = CFS_ST_SKIP;
				else if (|snz_hit)
					state_d = CFS_ST_SKIP;
			end
			CFS_ST_OPERAND: begin
				if (fetch.valid)
					state_d = cmp_imm_eq ? CFS_ST_SKIP
						: CFS_ST_RUN;
			end
			CFS_ST_SKIP: begin
				if (fetch.valid)
					state_d = CFS_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			state_q <= CFS_ST_RUN;
		else
			state_q <= state_d;
	end

	// advance notice for the core, registered so it is glitch free
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			skip_next_q <= 1'b0;
			operand_next_q <= 1'b0;
		end else begin
			skip_next_q <= state_d == CFS_ST_SKIP;
			operand_next_q <= state_d == CFS_ST_OPERAND;
		end
	end

	// a skipped word is still fetched, only its effect is dropped;
	// no carry path exists here, so carry cannot change
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			inhibit_q <= 1'b0;
		else
			inhibit_q <= fetch.valid
				&& state_q == CFS_ST_SKIP;
	end

	// request flags: a new request beats the clear by the test
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			ext_request_flag_q <= 2'h0;
		else
			ext_request_flag_q <= ext_req_set
				| (ext_request_flag_q & ~flag_clr);
	end

	// enable bits of the first interrupt control register
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			ext_irq_enable_q <= `CFS_RST_CTRL;
		else if (reg_wr.en && reg_wr.addr == `CFS_OFS_CTRL
			&& reg_wr.strb[0])
			ext_irq_enable_q <= reg_wr.data[1:0];
	end

	// events for the interrupt status register
	always_comb begin
		evt_set = '0;
		evt_set[`CFS_EVT_CMP_SKIP] = (state_q == CFS_ST_OPERAND
			&& fetch.valid && cmp_imm_eq) || (is_mem && cmp_mem_eq);
		evt_set[`CFS_EVT_EXT0_SKIP] = snz_hit[0];
		evt_set[`CFS_EVT_EXT1_SKIP] = snz_hit[1];
		evt_set[`CFS_EVT_FLAG_NOP] = |snz_nop;
	end

	// sticky status, write one to clear; a new event wins
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			evt_stat_q <= '0;
		else if (reg_wr.en && reg_wr.addr == `CFS_OFS_EVT_STAT
			&& reg_wr.strb[0])
			evt_stat_q <= evt_set
				| (evt_stat_q & ~reg_wr.data[`CFS_EVT_W-1:0]);
		else
			evt_stat_q <= evt_stat_q | evt_set;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			evt_mask_q <= `CFS_RST_MASK;
		else if (reg_wr.en && reg_wr.addr == `CFS_OFS_EVT_MASK
			&& reg_wr.strb[0])
			evt_mask_q <= reg_wr.data[`CFS_EVT_W-1:0];
	end

	// one cycle behind the status bits, by design of the flop output
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			irq_q <= 1'b0;
		else
			irq_q <= |(evt_stat_q & evt_mask_q);
	end

	// read lookup; unmapped reads return zero and an error
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (rd_addr)
			`CFS_OFS_CTRL: rd_data[1:0] = ext_irq_enable_q;
			`CFS_OFS_FLAGS: rd_data[1:0] = ext_request_flag_q;
			`CFS_OFS_EVT_STAT: rd_data[`CFS_EVT_W-1:0] = evt_stat_q;
			`CFS_OFS_EVT_MASK: rd_data[`CFS_EVT_W-1:0] = evt_mask_q;
			`CFS_OFS_STATE: rd_data[1:0] = state_q;
			default: rd_hit = 1'b0;
		endcase
	end

endmodule

/* include/cfs_map.svh */
`ifndef CFS_MAP_SVH
`define CFS_MAP_SVH

// instruction words, 10 bits each
`define CFS_OP_SKIP_ACC_IMM 10'h025
`define CFS_OP_SKIP_ACC_MEM 10'h026
`define CFS_OP_SKIP_EXT0 10'h038
`define CFS_OP_SKIP_EXT1 10'h039

// register byte offsets
`define CFS_OFS_CTRL 5'h00
`define CFS_OFS_FLAGS 5'h04
`define CFS_OFS_EVT_STAT 5'h08
`define CFS_OFS_EVT_MASK 5'h0c
`define CFS_OFS_STATE 5'h10

// field positions
`define CFS_CTRL_EXT0_EN 0
`define CFS_CTRL_EXT1_EN 1
`define CFS_EVT_CMP_SKIP 0
`define CFS_EVT_EXT0_SKIP 1
`define CFS_EVT_EXT1_SKIP 2
`define CFS_EVT_FLAG_NOP 3
`define CFS_EVT_W 4

// reset values and answers
`define CFS_RST_CTRL 2'h0
`define CFS_RST_MASK 4'h0
`define CFS_RESP_OKAY 2'h0
`define CFS_RESP_SLVERR 2'h2

`endif

/* include/cfs_pkg.sv */
package cfs_pkg;

	typedef enum logic [1:0] {
		CFS_ST_RUN,
		CFS_ST_OPERAND,
		CFS_ST_SKIP
	} cfs_state_e;

	// one fetched word from the fetch stage
	typedef struct packed {
		logic valid;
		logic [9:0] word;
	} cfs_fetch_s;

	// operands offered by the datapath
	typedef struct packed {
		logic [3:0] acc;
		logic [3:0] mem;
	} cfs_operand_s;

	// register write handed from the bus slave
	typedef struct packed {
		logic en;
		logic [4:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} cfs_regwr_s;

endpackage
